// *** logic/pin_synchronizer.v ***
/*
 * Two-flop synchroniser for a vector of asynchronous pin levels.
 * Assumes each bit is an independent level; no coherence across bits.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_synchronizer #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // Async levels in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_value,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // First stage feeds only the second
            always @(posedge clk) begin
                if (srst) begin
                    meta[i]   <= reset_value[i];
                    stable[i] <= reset_value[i];
                end else begin
                    meta[i]   <= async_in[i];
                    stable[i] <= meta[i];
                end
            end
        end
    endgenerate

    assign sync_out = stable;

endmodule

`default_nettype wire

// *** logic/reset_strap_latch.v ***
/*
 * Strap latch: samples the multiplexed strap pins on the release of the
 * device reset pin, holds the settings, selects each pin's internal
 * pulls and hands the pins back to their normal functions.
 * Assumes the core logic drives func_out/func_oe on clk, and that the
 * pad ring resolves pin level from out/oe and the pull enables.
 */
//
// Contract
// - Every strap pin level is captured on the rising edge of the device reset pin and held.
// - Shortly after reset release the pins go back to their normal functions.
// - With no external load the internal pulls give the default level, on boot-select and bus-lock only for identity zero.
// - Boot strap 0 boots from external memory at once, 1 idles waiting for an outside master.
// - Interrupt strap 0 leaves the four interrupts disabled and edge-sensitive, 1 enables level mode.
// - Link width strap 0 gives a 1-bit default input width, 1 gives 4-bit.
// - Write policy 0 allows one write per config register after reset, 1 allows any number.
// - Pulls follow the reset pin: strap pulls in reset, then driven pins or pull-ups after.
// - Boot-select and bus-lock pulls are on only for the processor with identity zero.
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.vh"

module reset_strap_latch #(
    parameter HANDOVER_CYCLES = `HANDOVER_CYCLES
) (
    // Clock and block reset
    input  wire       clk,
    input  wire       srst,
    // Device reset pin and identity pins (asynchronous)
    input  wire       rst_in_n,
    input  wire [2:0] processor_id,
    // Strap pins: pad level in, drive and enable out
    input  wire [6:0] strap_pin_in,
    output reg  [6:0] strap_pin_out,
    output reg  [6:0] strap_pin_oe,
    output reg  [6:0] pull_up_en,
    output reg  [6:0] pull_down_en,
    // Normal-function drive from the core
    input  wire [6:0] func_out,
    input  wire [6:0] func_oe,
    // Captured straps
    output reg        boot_source_strap,
    output reg        interrupt_enable_strap,
    output reg        link_width_strap,
    output reg        config_write_policy_strap,
    output reg        test_strap_one,
    output reg        test_strap_two,
    output reg        test_strap_three,
    // Decoded settings
    output reg        boot_from_external_memory,
    output reg        wait_for_external_boot,
    output reg        external_interrupt_inputs_enable,
    output reg        external_interrupt_inputs_level,
    output reg        link_input_width_4bit,
    output reg        test_strap_fault,
    output reg        pins_normal,
    // Config register write gating
    input  wire       system_config_register_wr,
    input  wire       memory_controller_config_register_wr,
    output reg        system_config_register_wr_ok,
    output reg        memory_controller_config_register_wr_ok
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise pins

    wire [10:0] sync_in;
    wire [10:0] sync_out;
    wire        rst_pin_sync;
    wire [6:0]  strap_sync;
    wire [2:0]  id_sync;

    assign sync_in = {rst_in_n, processor_id, strap_pin_in};

    // Reset pin held low and straps at defaults through block reset
    pin_synchronizer #(
        .WIDTH       (11)
    ) u_sync (
        .clk         (clk),
        .srst        (srst),
        .async_in    (sync_in),
        .reset_value ({1'h0, 3'h0, `STRAP_DEFAULTS}),
        .sync_out    (sync_out)
    );

    assign strap_sync   = sync_out[6:0];
    assign id_sync      = sync_out[9:7];
    assign rst_pin_sync = sync_out[10];

    ////////////////////////////////////////////////////////////////////////////
    // Phase machine

    reg [1:0]                       phase;
    reg [1:0]                       next_phase;
    reg [`HANDOVER_COUNT_WIDTH-1:0] handover_count;
    reg [`HANDOVER_COUNT_WIDTH-1:0] next_handover_count;
    reg [6:0]                       captured;
    reg [6:0]                       next_captured;
    wire                            capture_now;
    wire                            id_primary;

    // Full-width count end, cut to the counter width on purpose
    localparam integer                     HANDOVER_LAST_FULL = HANDOVER_CYCLES - 1;
    localparam [`HANDOVER_COUNT_WIDTH-1:0] HANDOVER_LAST      =
        HANDOVER_LAST_FULL[`HANDOVER_COUNT_WIDTH-1:0];

    // Rising edge of the reset pin seen as leaving the reset phase
    assign capture_now = (phase == `PHASE_RESET) && rst_pin_sync;
    assign id_primary  = (id_sync == `PROCESSOR_ID_PRIMARY);

    always @* begin
        next_phase          = phase;
        next_handover_count = handover_count;
        next_captured       = captured;
        case (phase)
            `PHASE_RESET: begin
                if (rst_pin_sync) begin
                    next_captured       = strap_sync;
                    next_handover_count = {`HANDOVER_COUNT_WIDTH{1'b0}};
                    next_phase          = `PHASE_HANDOVER;
                end
            end
            `PHASE_HANDOVER: begin
                if (handover_count == HANDOVER_LAST) begin
                    next_phase = `PHASE_NORMAL;
                end else begin
                    next_handover_count = handover_count + 1'b1;
                end
            end
            `PHASE_NORMAL: begin
                next_phase = `PHASE_NORMAL;
            end
            default: begin
                next_phase = `PHASE_RESET;
            end
        endcase
        // A fresh reset always wins; captured values are held meanwhile
        if (!rst_pin_sync) begin
            next_phase = `PHASE_RESET;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            phase          <= `PHASE_RESET;
            handover_count <= {`HANDOVER_COUNT_WIDTH{1'b0}};
            captured       <= `STRAP_DEFAULTS;
        end else begin
            phase          <= next_phase;
            handover_count <= next_handover_count;
            captured       <= next_captured;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad control

    reg [6:0] next_pin_out;
    reg [6:0] next_pin_oe;
    reg [6:0] next_pull_up;
    reg [6:0] next_pull_down;
    reg [6:0] id_gate;

    always @* begin
        // Identity-zero pulls vanish on other processors
        id_gate = id_primary ? 7'h7F : ~`ID_ZERO_ONLY_MASK;
        if (next_phase == `PHASE_NORMAL) begin
            next_pin_out   = func_out;
            next_pin_oe    = `NORMAL_DRIVEN_MASK | (func_oe & ~`NORMAL_DRIVEN_MASK);
            next_pull_up   = `NORMAL_PULL_UP_MASK & id_gate;
            next_pull_down = 7'h00;
        end else begin
            // Pins float onto the pulls left by id_gate, so the default is sampled where a pull remains
            next_pin_out   = 7'h00;
            next_pin_oe    = 7'h00;
            next_pull_up   = `RESET_PULL_UP_MASK & id_gate;
            next_pull_down = `RESET_PULL_DOWN_MASK & id_gate;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            strap_pin_out <= 7'h00;
            strap_pin_oe  <= 7'h00;
            pull_up_en    <= 7'h00;
            pull_down_en  <= 7'h00;
            pins_normal   <= 1'b0;
        end else begin
            strap_pin_out <= next_pin_out;
            strap_pin_oe  <= next_pin_oe;
            pull_up_en    <= next_pull_up;
            pull_down_en  <= next_pull_down;
            pins_normal   <= (next_phase == `PHASE_NORMAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings

    always @(posedge clk) begin
        if (srst) begin
            boot_source_strap                <= 1'b0;
            interrupt_enable_strap           <= 1'b0;
            link_width_strap                 <= 1'b0;
            config_write_policy_strap        <= 1'b0;
            test_strap_one                   <= 1'b1;
            test_strap_two                   <= 1'b1;
            test_strap_three                 <= 1'b1;
            boot_from_external_memory        <= 1'b1;
            wait_for_external_boot           <= 1'b0;
            external_interrupt_inputs_enable <= 1'b0;
            external_interrupt_inputs_level  <= 1'b0;
            link_input_width_4bit            <= 1'b0;
            test_strap_fault                 <= 1'b0;
        end else begin
            boot_source_strap                <= next_captured[`PIN_BOOT_MEMORY_SELECT];
            interrupt_enable_strap           <= next_captured[`PIN_BUS_MASTER_OUT];
            link_width_strap                 <= next_captured[`PIN_TIMER_EXPIRED];
            config_write_policy_strap        <= next_captured[`PIN_BUS_LOCK];
            test_strap_one                   <= next_captured[`PIN_LINK1_COMPARE];
            test_strap_two                   <= next_captured[`PIN_LINK2_COMPARE];
            test_strap_three                 <= next_captured[`PIN_LINK3_COMPARE];
            boot_from_external_memory        <= ~next_captured[`PIN_BOOT_MEMORY_SELECT];
            wait_for_external_boot           <= next_captured[`PIN_BOOT_MEMORY_SELECT];
            external_interrupt_inputs_enable <= next_captured[`PIN_BUS_MASTER_OUT];
            external_interrupt_inputs_level  <= next_captured[`PIN_BUS_MASTER_OUT];
            link_input_width_4bit            <= next_captured[`PIN_TIMER_EXPIRED];
            // Flags a board that overdrove a test strap
            test_strap_fault <= ((next_captured & `TEST_STRAP_MASK) != `TEST_STRAP_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Config register write gating

    reg  sys_written;
    reg  mem_written;
    wire writes_open;
    wire sys_ok;
    wire mem_ok;

    // No writes while the pins are still in strap mode
    assign writes_open = (phase == `PHASE_NORMAL) && (next_phase == `PHASE_NORMAL);
    assign sys_ok = writes_open && system_config_register_wr &&
                    (captured[`PIN_BUS_LOCK] || !sys_written);
    assign mem_ok = writes_open && memory_controller_config_register_wr &&
                    (captured[`PIN_BUS_LOCK] || !mem_written);

    always @(posedge clk) begin
        if (srst) begin
            sys_written                             <= 1'b0;
            mem_written                             <= 1'b0;
            system_config_register_wr_ok            <= 1'b0;
            memory_controller_config_register_wr_ok <= 1'b0;
        end else begin
            // Each new capture reopens the one-time write
            if (capture_now) begin
                sys_written <= 1'b0;
                mem_written <= 1'b0;
            end else begin
                sys_written <= sys_written | sys_ok;
                mem_written <= mem_written | mem_ok;
            end
            system_config_register_wr_ok            <= sys_ok;
            memory_controller_config_register_wr_ok <= mem_ok;
        end
    end

endmodule

`default_nettype wire

// *** logic/strap_consts.vh ***
/*
 * Constants for the strap latch: pin indices, pull masks, strap
 * defaults, phase codes and the hand-back delay.
 * Assumes the includer uses the 100 MHz core clock.
 */
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// Pin indices into the seven-bit strap vectors
`define PIN_BOOT_MEMORY_SELECT  0
`define PIN_BUS_MASTER_OUT      1
`define PIN_TIMER_EXPIRED       2
`define PIN_BUS_LOCK            3
`define PIN_LINK1_COMPARE       4
`define PIN_LINK2_COMPARE       5
`define PIN_LINK3_COMPARE       6
`define STRAP_PIN_COUNT         7

// Levels the internal pulls give with nothing overdriving the pins
`define STRAP_DEFAULTS          7'h70

// Pull selection while the device reset pin is low
`define RESET_PULL_DOWN_MASK    7'h0F
`define RESET_PULL_UP_MASK      7'h70
// Pull selection in normal operation
`define NORMAL_PULL_UP_MASK     7'h09
// Pins whose pulls exist only on the processor with identity zero
`define ID_ZERO_ONLY_MASK       7'h09
// Pins always driven in normal operation
`define NORMAL_DRIVEN_MASK      7'h76
// Test-mode straps
`define TEST_STRAP_MASK         7'h70

`define PROCESSOR_ID_WIDTH      3
`define PROCESSOR_ID_PRIMARY    3'h0

// Phases of the pin hand-back
`define PHASE_RESET             2'h0
`define PHASE_HANDOVER          2'h1
`define PHASE_NORMAL            2'h2

// Delay from capture to handing pins back to normal function
`define CLK_PERIOD_NS           10
`define HANDOVER_NS             40
`define HANDOVER_CYCLES         ((`HANDOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HANDOVER_COUNT_WIDTH    4

`endif

// *** verification/board_straps.sv ***
/* Board side of the strap pins: external straps, pad drive and pulls.
   Assumes the board never overdrives the test-mode straps. */
`timescale 1ns/1ps
`default_nettype none
module board_straps (
    // Clock
    input  wire logic       clk,
    // Device pad controls
    input  wire logic [6:0] pad_out,
    input  wire logic [6:0] pad_oe,
    input  wire logic [6:0] pull_up,
    input  wire logic [6:0] pull_down,
    // Board straps
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    // Resolved pad level
    output wire logic [6:0] level
);
    // Undriven, unpulled pins wander so a stale level is never trusted
    logic [6:0] flt = 7'h55;
    wire  [6:0] ext_ok = ext_en & 7'h0F;
    wire  [6:0] rest = ~pad_oe & ~ext_ok;
    always @(posedge clk) flt <= ~flt;
    assign level = (pad_oe & pad_out) | (~pad_oe & ext_ok & ext_val)
        | (rest & (pull_up | (~pull_down & flt)));
endmodule
`default_nettype wire

// *** verification/reset_strap_latch_sva.sv ***
/* Checker for the strap latch: capture, decode, pad and write-gate timing.
   Assumes processor_id only changes while srst is high. */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_latch_sva #(
    parameter HANDOVER_CYCLES = 4
) (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       rst_in_n,
    input wire logic [2:0] processor_id,
    input wire logic [6:0] strap_pin_in,
    input wire logic [6:0] strap_pin_oe,
    input wire logic [6:0] pull_up_en,
    input wire logic [6:0] pull_down_en,
    input wire logic       boot_source_strap,
    input wire logic       interrupt_enable_strap,
    input wire logic       link_width_strap,
    input wire logic       config_write_policy_strap,
    input wire logic       test_strap_one,
    input wire logic       test_strap_two,
    input wire logic       test_strap_three,
    input wire logic       boot_from_external_memory,
    input wire logic       wait_for_external_boot,
    input wire logic       external_interrupt_inputs_enable,
    input wire logic       external_interrupt_inputs_level,
    input wire logic       link_input_width_4bit,
    input wire logic       pins_normal,
    input wire logic       system_config_register_wr,
    input wire logic       memory_controller_config_register_wr,
    input wire logic       system_config_register_wr_ok,
    input wire logic       memory_controller_config_register_wr_ok
);
    localparam int NORM_LAT = HANDOVER_CYCLES + 3;
    localparam int NORM_PRE = HANDOVER_CYCLES + 2;
    wire [6:0] caps = {test_strap_three, test_strap_two, test_strap_one,
        config_write_policy_strap, link_width_strap, interrupt_enable_strap, boot_source_strap};
    // Identity pulls only exist on the primary processor
    wire [6:0] id_mask = (processor_id == 3'h0) ? 7'h7F : 7'h76;
    reg  [2:0] age;
    reg        sys_done;
    reg        mem_done;
    wire       sys_used = sys_done || system_config_register_wr_ok;
    wire       mem_used = mem_done || memory_controller_config_register_wr_ok;
    always @(posedge clk) begin
        if (srst) begin
            age <= 3'h0;
            sys_done <= 1'b0;
            mem_done <= 1'b0;
        end else begin
            age <= (age == 3'h7) ? age : age + 3'h1;
            sys_done <= pins_normal && sys_used;
            mem_done <= pins_normal && mem_used;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    cap_value_a: assert property ($rose(rst_in_n) ##1 rst_in_n[*2] |->
        ##1 caps == $past(strap_pin_in, 3)) else $error("strap capture wrong");
    cap_hold_a: assert property (!($past(rst_in_n, 3) && !$past(rst_in_n, 4))
        |-> $stable(caps)) else $error("straps changed without capture");
    boot_decode_a: assert property (boot_from_external_memory == !boot_source_strap
        && wait_for_external_boot == boot_source_strap) else $error("boot decode wrong");
    irq_decode_a: assert property (external_interrupt_inputs_enable == interrupt_enable_strap
        && external_interrupt_inputs_level == interrupt_enable_strap) else $error("irq decode");
    width_decode_a: assert property (link_input_width_4bit == link_width_strap)
        else $error("link width decode wrong");
    reset_pads_a: assert property (age == 3'h7 && !$past(rst_in_n, 3) |-> strap_pin_oe == 7'h00
        && pull_down_en == (7'h0F & id_mask) && pull_up_en == 7'h70) else $error("reset pads");
    normal_pads_a: assert property (pins_normal |-> (strap_pin_oe & 7'h76) == 7'h76
        && pull_down_en == 7'h00 && pull_up_en == (7'h09 & id_mask)) else $error("normal pads");
    handback_late_a: assert property ($rose(rst_in_n) |-> ##NORM_LAT pins_normal)
        else $error("pins not handed back");
    handback_early_a: assert property ($rose(rst_in_n) |-> ##NORM_PRE !pins_normal)
        else $error("pins handed back early");
    write_accept_a: assert property (system_config_register_wr && pins_normal && rst_in_n
        && $past(rst_in_n, 3) && (config_write_policy_strap || !sys_used)
        |=> system_config_register_wr_ok) else $error("write not accepted");
    write_refuse_a: assert property (memory_controller_config_register_wr_ok |->
        $past(memory_controller_config_register_wr) && $past(pins_normal)
        && !$past(mem_used && !config_write_policy_strap)) else $error("write not refused");
endmodule
bind reset_strap_latch reset_strap_latch_sva #(.HANDOVER_CYCLES(HANDOVER_CYCLES)) u_sva (.*);
`default_nettype wire

// *** verification/reset_strap_latch_tb.sv ***
/* Self-checking bench for the strap latch with a board strap model.
   Assumes a 100 MHz clock and the default hand-back delay. */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_latch_tb;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       rst_in_n = 1'b0;
    logic [2:0] processor_id = 3'h0;
    logic [6:0] ext_en = 7'h00;
    logic [6:0] ext_val = 7'h00;
    logic [6:0] func_out = 7'h00;
    logic [6:0] func_oe = 7'h00;
    logic       sys_wr = 1'b0;
    logic       mem_wr = 1'b0;
    wire  [6:0] pin_in, pin_out, pin_oe, pu, pd;
    wire        boot, irq, width, pol, t1, t2, t3, ext_boot, wait_boot;
    wire        irq_en, irq_lvl, w4, fault, normal, sys_ok, mem_ok;
    wire  [6:0] caps = {t3, t2, t1, pol, width, irq, boot};
    int         n_fail = 0;
    int         comparisons = 0;
    int         cycles = 0;
    initial forever #5 clk = ~clk;
    reset_strap_latch u_reset_strap_latch (.clk(clk), .srst(srst), .rst_in_n(rst_in_n),
        .processor_id(processor_id), .strap_pin_in(pin_in), .strap_pin_out(pin_out),
        .strap_pin_oe(pin_oe), .pull_up_en(pu), .pull_down_en(pd), .func_out(func_out),
        .func_oe(func_oe), .boot_source_strap(boot), .interrupt_enable_strap(irq),
        .link_width_strap(width), .config_write_policy_strap(pol), .test_strap_one(t1),
        .test_strap_two(t2), .test_strap_three(t3), .boot_from_external_memory(ext_boot),
        .wait_for_external_boot(wait_boot), .external_interrupt_inputs_enable(irq_en),
        .external_interrupt_inputs_level(irq_lvl), .link_input_width_4bit(w4),
        .test_strap_fault(fault), .pins_normal(normal), .system_config_register_wr(sys_wr),
        .memory_controller_config_register_wr(mem_wr), .system_config_register_wr_ok(sys_ok),
        .memory_controller_config_register_wr_ok(mem_ok));
    board_straps u_board_straps (.clk(clk), .pad_out(pin_out), .pad_oe(pin_oe), .pull_up(pu),
        .pull_down(pd), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic strap(input logic [6:0] en, input logic [6:0] val);
        @(posedge clk) rst_in_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_en <= en;
        ext_val <= val;
        repeat (6) @(posedge clk);
        rst_in_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic s, input logic m, input logic [6:0] exp);
        @(posedge clk) sys_wr <= s;
        mem_wr <= m;
        @(posedge clk) sys_wr <= 1'b0;
        mem_wr <= 1'b0;
        #1;
        chk("write accept", exp, {5'h00, sys_ok, mem_ok});
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_codes;
        logic [3:0] v;
        strap(7'h00, 7'h00);
        chk("default straps", 7'h70, caps);
        chk("test strap fault", 7'h00, {6'h00, fault});
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            strap(7'h0F, {3'h0, v});
            chk("straps", {3'h7, v}, caps);
            chk("decode", {2'h0, ~v[0], v[0], v[1], v[1], v[2]},
                {2'h0, ext_boot, wait_boot, irq_en, irq_lvl, w4});
            wr(1'b1, 1'b1, 7'h03);
            wr(1'b1, 1'b0, {5'h00, v[3], 1'b0});
            wr(1'b0, 1'b1, {6'h00, v[3]});
        end
        $display("strap codes done");
    endtask
    task automatic t_hold;
        strap(7'h0F, 7'h05);
        @(posedge clk) ext_val <= 7'h0A;
        func_out <= 7'h2A;
        func_oe <= 7'h09;
        repeat (4) @(posedge clk);
        #1;
        chk("held straps", 7'h75, caps);
        chk("normal oe", 7'h7F, pin_oe);
        chk("normal out", 7'h22, pin_out & 7'h76);
        chk("normal pulls", 7'h09, pu | pd);
        chk("pins normal flag", 7'h01, {6'h00, normal});
        @(posedge clk) rst_in_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("reset oe", 7'h00, pin_oe);
        chk("reset pull down", 7'h0F, pd);
        chk("straps in reset", 7'h75, caps);
        chk("pins strap flag", 7'h00, {6'h00, normal});
        $display("hold and pads done");
    endtask
    task automatic t_id(input logic [2:0] id, input logic [6:0] up, input logic [6:0] dn);
        @(posedge clk) srst <= 1'b1;
        processor_id <= id;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        strap(7'h0F, 7'h00);
        chk("id normal pull up", up, pu);
        @(posedge clk) rst_in_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("id reset pull down", dn, pd);
        $display("identity pulls done");
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_codes();
        t_hold();
        t_id(3'h5, 7'h00, 7'h06);
        t_id(3'h0, 7'h09, 7'h0F);
        wrap_up();
    end
endmodule
`default_nettype wire
